// ---- verilog/spcd_top.sv ----
// Chosen here: the Wishbone register port.
`timescale 1ns/10ps
`default_nettype none
`include "spcd_defines.svh"

module spcd_top
  import spcd_pkg::*;
#(
  parameter int FIFO_DEPTH = 8
) (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [17:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Serial link pins
  input wire logic spi_sclk,
  input wire logic spi_sel_n,
  input wire logic spi_rx,
  output logic spi_tx,
  output logic spi_tx_oe,
  // DMA memory ports
  output logic [15:0] dma_rd_addr,
  input wire logic [7:0] dma_rd_data,
  output logic dma_wr_valid,
  output logic [15:0] dma_wr_addr,
  output logic [7:0] dma_wr_data,
  // Block completion
  output logic block_irq
);

  // ----------------------------------------------------------------
  // Address decode helper
  // ----------------------------------------------------------------
  function automatic logic hit(input logic [17:0] adr,
                               input logic [15:0] idx);
    hit = (adr[17:2] == idx) && (adr[1:0] == 2'b00);
  endfunction

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [2:0] sync1_q; // First synchroniser stage
  logic [2:0] sync2_q; // Second synchroniser stage
  logic sclk_prev_q; // Delayed clock for edges
  logic sclk_rise; // Link clock rising edge
  logic sclk_fall; // Link clock falling edge
  logic sel_act; // Frame active
  logic rx_s; // Synchronised data in
  logic wb_req; // Bus request pending
  logic wr_stb; // Write takes effect
  logic rd_stb; // Read takes effect
  logic [1:0] crc_sel_q; // Polynomial select
  logic crc_en_q; // CRC enabled
  logic crc_rx_q; // Stream select
  logic [15:0] crc_q; // Accumulator
  logic [15:0] crc_step; // Accumulator after a bit
  logic crc_bit; // Bit fed to the CRC
  logic mode_block_q; // Block mode
  logic mode_fdx_q; // Full duplex
  logic [2:0] tx_len_q; // Transmit bit length
  logic [2:0] rx_len_q; // Receive bit length
  logic [15:0] tx_base_q; // Transmit DMA base
  logic [10:0] tx_cnt_q; // Transmit DMA count
  logic [15:0] rx_base_q; // Receive DMA base
  logic [10:0] rx_cnt_q; // Receive DMA count
  logic [7:0] tx_sh_q; // Transmit shifter
  logic [3:0] tx_left_q; // Bits still to send
  logic [7:0] rx_sh_q; // Receive shifter
  logic [3:0] rx_bits_q; // Bits gathered
  logic [3:0] rx_need; // Bits per received unit
  logic [7:0] rx_byte; // Completed unit
  logic rx_done; // Unit complete
  logic fifo_push; // Push into queue
  logic fifo_full; // Queue full
  logic fifo_empty; // Queue empty
  logic [7:0] fifo_head; // Oldest byte
  logic ovf_q; // Queue overflow seen
  spcd_blk_e blk_q; // Block engine state
  logic [10:0] tx_idx_q; // Bytes fetched
  logic [10:0] rx_idx_q; // Bytes stored
  logic fetch_q; // Fetch in progress
  logic blk_done; // Block completion pulse
  logic irq_q; // Block interrupt flag
  logic [15:0] rd_val; // Read mux

  // ----------------------------------------------------------------
  // Pin synchronisers and edge detect
  // ----------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_sync
      // Two flops per pin
      always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
          sync1_q[gi] <= (gi == 1) ? 1'b1 : 1'b0;
          sync2_q[gi] <= (gi == 1) ? 1'b1 : 1'b0;
        end else begin
          sync1_q[gi] <= (gi == 0) ? spi_sclk :
                         (gi == 1) ? spi_sel_n : spi_rx;
          sync2_q[gi] <= sync1_q[gi];
        end
      end
    end
  endgenerate

  // Edge history of link clock
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      sclk_prev_q <= 1'b0;
    end else begin
      sclk_prev_q <= sync2_q[0];
    end
  end

  assign sel_act = ~sync2_q[1];
  assign rx_s = sync2_q[2];
  assign sclk_rise = sel_act & sync2_q[0] & ~sclk_prev_q;
  assign sclk_fall = sel_act & ~sync2_q[0] & sclk_prev_q;

  // ----------------------------------------------------------------
  // Wishbone handshake
  // ----------------------------------------------------------------
  assign wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wr_stb = wb_req & wb_we_i;
  assign rd_stb = wb_req & ~wb_we_i;

  // Ack one cycle after the request
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= wb_req;
    end
  end

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  // Software-written setup; CRC and mode fields written only when the byte lane of their top bit is selected, DMA base and count byte by byte
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      crc_sel_q <= 2'h0;
      crc_en_q <= 1'b0;
      crc_rx_q <= 1'b0;
      mode_block_q <= 1'b0;
      mode_fdx_q <= 1'b0;
      tx_len_q <= 3'h0;
      rx_len_q <= 3'h0;
      tx_base_q <= 16'h0000;
      tx_cnt_q <= 11'h000;
      rx_base_q <= 16'h0000;
      rx_cnt_q <= 11'h000;
    end else if (wr_stb) begin
      if (hit(wb_adr_i, `SPCD_IDX_CRC_CTRL) && wb_sel_i[1]) begin
        crc_sel_q <= wb_dat_i[`SPCD_CRC_SEL_HI:`SPCD_CRC_SEL_LO];
        crc_en_q <= wb_dat_i[`SPCD_CRC_EN_BIT];
        crc_rx_q <= wb_dat_i[`SPCD_CRC_RX_BIT];
      end
      if (hit(wb_adr_i, `SPCD_IDX_MODE) && wb_sel_i[0]) begin
        mode_block_q <= wb_dat_i[`SPCD_MODE_BLOCK];
        mode_fdx_q <= wb_dat_i[`SPCD_MODE_FDX];
        tx_len_q <= wb_dat_i[`SPCD_MODE_TXL_LO +: 3];
      end
      if (hit(wb_adr_i, `SPCD_IDX_MODE) && wb_sel_i[1]) begin
        rx_len_q <= wb_dat_i[`SPCD_MODE_RXL_LO +: 3];
      end
      if (hit(wb_adr_i, `SPCD_IDX_TX_BASE)) begin
        if (wb_sel_i[0]) tx_base_q[7:0] <= wb_dat_i[7:0];
        if (wb_sel_i[1]) tx_base_q[15:8] <= wb_dat_i[15:8];
      end
      if (hit(wb_adr_i, `SPCD_IDX_TX_LEN)) begin
        if (wb_sel_i[0]) tx_cnt_q[7:0] <= wb_dat_i[7:0];
        if (wb_sel_i[1]) tx_cnt_q[10:8] <= wb_dat_i[10:8];
      end
      if (hit(wb_adr_i, `SPCD_IDX_RX_BASE)) begin
        if (wb_sel_i[0]) rx_base_q[7:0] <= wb_dat_i[7:0];
        if (wb_sel_i[1]) rx_base_q[15:8] <= wb_dat_i[15:8];
      end
      if (hit(wb_adr_i, `SPCD_IDX_RX_LEN)) begin
        if (wb_sel_i[0]) rx_cnt_q[7:0] <= wb_dat_i[7:0];
        if (wb_sel_i[1]) rx_cnt_q[10:8] <= wb_dat_i[10:8];
      end
    end
  end

  // ----------------------------------------------------------------
  // CRC accumulator
  // ----------------------------------------------------------------
  // Half duplex follows whichever direction is moving
  always_comb begin
    if (mode_fdx_q) begin
      crc_bit = crc_rx_q ? rx_s : tx_sh_q[7];
    end else begin
      crc_bit = (tx_left_q != 4'h0) ? tx_sh_q[7] : rx_s;
    end
  end

  spcd_crc u_crc (
    .crc_cur(crc_q),
    .bit_in(crc_bit),
    .poly_sel(spcd_poly_e'(crc_sel_q)),
    .crc_next(crc_step)
  );

  // Software write and preset win over a serial step
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      crc_q <= `SPCD_CRC_RST;
    end else if (wr_stb && hit(wb_adr_i, `SPCD_IDX_CRC_CTRL) &&
                 wb_sel_i[1] && wb_dat_i[`SPCD_CRC_CLR_BIT]) begin
      crc_q <= `SPCD_CRC_RST;
    end else if (wr_stb && hit(wb_adr_i, `SPCD_IDX_CRC_VAL)) begin
      if (wb_sel_i[0]) crc_q[7:0] <= wb_dat_i[7:0];
      if (wb_sel_i[1]) crc_q[15:8] <= wb_dat_i[15:8];
    end else if (crc_en_q && sclk_rise) begin
      crc_q <= crc_step;
    end
  end

  // ----------------------------------------------------------------
  // Receive shifter and queue
  // ----------------------------------------------------------------
  assign rx_need = (rx_len_q == 3'h0) ? 4'h8 : {1'b0, rx_len_q};
  assign rx_done = sclk_rise && ((rx_bits_q + 4'h1) == rx_need);
  assign rx_byte = {rx_sh_q[6:0], rx_s};
  assign fifo_push = rx_done & ~mode_block_q;

  // Gather bits on rising edges, restart per frame
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rx_sh_q <= 8'h00;
      rx_bits_q <= 4'h0;
    end else if (!sel_act) begin
      rx_bits_q <= 4'h0;
    end else if (sclk_rise) begin
      rx_sh_q <= rx_byte;
      rx_bits_q <= rx_done ? 4'h0 : rx_bits_q + 4'h1;
    end
  end

  spcd_fifo #(
    .DW(8),
    .DEPTH(FIFO_DEPTH),
    .AW($clog2(FIFO_DEPTH))
  ) u_rxq (
    .clk(clk),
    .sys_rst(sys_rst),
    .push(fifo_push),
    .push_data(rx_byte),
    .pop(rd_stb && hit(wb_adr_i, `SPCD_IDX_DATA)),
    .head_q(fifo_head),
    .full(fifo_full),
    .empty(fifo_empty)
  );

  // Sticky overflow, dropped byte
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ovf_q <= 1'b0;
    end else if (fifo_push && fifo_full) begin
      ovf_q <= 1'b1;
    end else if (wr_stb && hit(wb_adr_i, `SPCD_IDX_STAT) && wb_sel_i[0]) begin
      ovf_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Transmit shifter
  // ----------------------------------------------------------------
  // Load from a data write or a DMA fetch; shift on falling edges
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      tx_sh_q <= 8'h00;
      tx_left_q <= 4'h0;
    end else if (wr_stb && hit(wb_adr_i, `SPCD_IDX_DATA) && wb_sel_i[0] &&
                 !mode_block_q) begin
      tx_sh_q <= wb_dat_i[7:0] << (4'h8 - tx_len_bits(tx_len_q));
      tx_left_q <= tx_len_bits(tx_len_q);
    end else if (fetch_q) begin
      tx_sh_q <= dma_rd_data << (4'h8 - tx_len_bits(tx_len_q));
      tx_left_q <= tx_len_bits(tx_len_q);
    end else if (sclk_fall && tx_left_q != 4'h0) begin
      tx_sh_q <= {tx_sh_q[6:0], 1'b0};
      tx_left_q <= tx_left_q - 4'h1;
    end
  end

  // Bits sent for a length code
  function automatic logic [3:0] tx_len_bits(input logic [2:0] len);
    tx_len_bits = (len == 3'h0) ? 4'h8 : {1'b0, len};
  endfunction

  // Pin drive follows the shifter
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      spi_tx <= 1'b0;
    end else begin
      spi_tx <= tx_sh_q[7];
    end
  end
  assign spi_tx_oe = sel_act;

  // ----------------------------------------------------------------
  // Block DMA engine
  // ----------------------------------------------------------------
  assign blk_done = (blk_q == SPCD_BLK_RUN) && (tx_idx_q == tx_cnt_q) &&
                    (rx_idx_q == rx_cnt_q) && (tx_left_q == 4'h0) && !fetch_q;

  // Start, fetch, store and finish
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      blk_q <= SPCD_BLK_IDLE;
      tx_idx_q <= 11'h000;
      rx_idx_q <= 11'h000;
      fetch_q <= 1'b0;
      dma_rd_addr <= 16'h0000;
      dma_wr_valid <= 1'b0;
      dma_wr_addr <= 16'h0000;
      dma_wr_data <= 8'h00;
    end else begin
      dma_wr_valid <= 1'b0;
      fetch_q <= 1'b0;
      case (blk_q)
        SPCD_BLK_IDLE: begin
          if (wr_stb && hit(wb_adr_i, `SPCD_IDX_MODE) && wb_sel_i[0] &&
              wb_dat_i[`SPCD_MODE_START] && wb_dat_i[`SPCD_MODE_BLOCK]) begin
            blk_q <= SPCD_BLK_RUN;
            tx_idx_q <= 11'h000;
            rx_idx_q <= 11'h000;
          end
        end
        SPCD_BLK_RUN: begin
          if (blk_done) begin
            blk_q <= SPCD_BLK_IDLE;
          end
          if (!fetch_q && tx_left_q == 4'h0 && tx_idx_q != tx_cnt_q) begin
            fetch_q <= 1'b1;
            dma_rd_addr <= tx_base_q + {5'h00, tx_idx_q};
            tx_idx_q <= tx_idx_q + 11'h001;
          end
          if (rx_done && rx_idx_q != rx_cnt_q) begin
            dma_wr_valid <= 1'b1;
            dma_wr_addr <= rx_base_q + {5'h00, rx_idx_q};
            dma_wr_data <= rx_byte;
            rx_idx_q <= rx_idx_q + 11'h001;
          end
        end
        default: begin
          blk_q <= SPCD_BLK_IDLE;
        end
      endcase
    end
  end

  // Completion flag, set beats clear
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      irq_q <= 1'b0;
    end else if (blk_done) begin
      irq_q <= 1'b1;
    end else if (wr_stb && hit(wb_adr_i, `SPCD_IDX_IRQ_CLR) &&
                 wb_sel_i[0] && wb_dat_i[`SPCD_IRQ_CLR_BIT]) begin
      irq_q <= 1'b0;
    end
  end
  assign block_irq = irq_q;

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  // Register select; unmapped reads return zero
  always_comb begin
    rd_val = 16'h0000;
    if (hit(wb_adr_i, `SPCD_IDX_CRC_CTRL)) begin
      rd_val[`SPCD_CRC_SEL_HI:`SPCD_CRC_SEL_LO] = crc_sel_q;
      rd_val[`SPCD_CRC_EN_BIT] = crc_en_q;
      rd_val[`SPCD_CRC_RX_BIT] = crc_rx_q;
      rd_val[`SPCD_CRC_ONE_BIT] = |crc_q;
      rd_val[`SPCD_CRC_ZERO_BIT] = ~&crc_q;
    end else if (hit(wb_adr_i, `SPCD_IDX_CRC_VAL)) begin
      rd_val = crc_q;
    end else if (hit(wb_adr_i, `SPCD_IDX_DATA)) begin
      rd_val = {8'h00, fifo_head};
    end else if (hit(wb_adr_i, `SPCD_IDX_TX_BASE)) begin
      rd_val = tx_base_q;
    end else if (hit(wb_adr_i, `SPCD_IDX_TX_LEN)) begin
      rd_val = {5'h00, tx_cnt_q};
    end else if (hit(wb_adr_i, `SPCD_IDX_RX_BASE)) begin
      rd_val = rx_base_q;
    end else if (hit(wb_adr_i, `SPCD_IDX_RX_LEN)) begin
      rd_val = {5'h00, rx_cnt_q};
    end else if (hit(wb_adr_i, `SPCD_IDX_MODE)) begin
      rd_val = {7'h00, rx_len_q, tx_len_q, 1'b0, mode_fdx_q, mode_block_q};
    end else if (hit(wb_adr_i, `SPCD_IDX_STAT)) begin
      rd_val = {10'h000, blk_q == SPCD_BLK_RUN, tx_left_q != 4'h0, ovf_q,
                fifo_full, ~fifo_empty, irq_q};
    end
  end

  // Data captured with the ack
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      wb_dat_o <= 32'h00000000;
    end else if (rd_stb) begin
      wb_dat_o <= {16'h0000, rd_val};
    end
  end

endmodule // spcd_top
`default_nettype wire

// ---- inc/spcd_defines.svh ----
`ifndef SPCD_DEFINES_SVH
`define SPCD_DEFINES_SVH

// ----------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define SPCD_IDX_MODE      16'hc0c8
`define SPCD_IDX_STAT      16'hc0ca
`define SPCD_IDX_IRQ_CLR   16'hc0d0
`define SPCD_IDX_CRC_CTRL  16'hc0d2
`define SPCD_IDX_CRC_VAL   16'hc0d4
`define SPCD_IDX_DATA      16'hc0d6
`define SPCD_IDX_TX_BASE   16'hc0d8
`define SPCD_IDX_TX_LEN    16'hc0da
`define SPCD_IDX_RX_BASE   16'hc0dc
`define SPCD_IDX_RX_LEN    16'hc0de

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define SPCD_CRC_SEL_HI    15
`define SPCD_CRC_SEL_LO    14
`define SPCD_CRC_EN_BIT    13
`define SPCD_CRC_CLR_BIT   12
`define SPCD_CRC_RX_BIT    11
`define SPCD_CRC_ONE_BIT   10
`define SPCD_CRC_ZERO_BIT  9
`define SPCD_MODE_BLOCK    0
`define SPCD_MODE_FDX      1
`define SPCD_MODE_START    2
`define SPCD_MODE_TXL_LO   3
`define SPCD_MODE_RXL_LO   6
`define SPCD_IRQ_CLR_BIT   0
`define SPCD_CNT_W         11

// ----------------------------------------------------------------
// Reset values and polynomials
// ----------------------------------------------------------------
`define SPCD_CRC_RST       16'hffff
`define SPCD_POLY_CCITT    16'h1021
`define SPCD_POLY_ALT      16'h8005
`define SPCD_POLY_CRC7     7'h09

`endif

// ---- inc/spcd_pkg.sv ----
package spcd_pkg;
  // Polynomial choice in the CRC control register
  typedef enum logic [1:0] {
    SPCD_POLY_CCITT16 = 2'h0,
    SPCD_POLY_CRC7    = 2'h1,
    SPCD_POLY_ALT16   = 2'h2,
    SPCD_POLY_RSVD    = 2'h3
  } spcd_poly_e;

  // Block transfer engine states, one-hot
  typedef enum logic [1:0] {
    SPCD_BLK_IDLE = 2'b01,
    SPCD_BLK_RUN  = 2'b10
  } spcd_blk_e;
endpackage

// ---- verilog/spcd_crc.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "spcd_defines.svh"

module spcd_crc
  import spcd_pkg::*;
(
  // Accumulator and incoming bit
  input wire logic [15:0] crc_cur,
  input wire logic bit_in,
  input wire spcd_poly_e poly_sel,
  // Accumulator after one bit
  output logic [15:0] crc_next
);

  // ----------------------------------------------------------------
  // One serial step, MSB first
  // ----------------------------------------------------------------
  logic fb16; // Feedback of 16-bit forms
  logic fb7; // Feedback of 7-bit form

  assign fb16 = bit_in ^ crc_cur[15];
  assign fb7 = bit_in ^ crc_cur[6];

  // Polynomial select
  always_comb begin
    case (poly_sel)
      SPCD_POLY_CRC7: begin
        crc_next = {crc_cur[15:7],
                    {crc_cur[5:0], 1'b0} ^ (fb7 ? `SPCD_POLY_CRC7 : 7'h00)};
      end
      SPCD_POLY_ALT16: begin
        crc_next = {crc_cur[14:0], 1'b0} ^ (fb16 ? `SPCD_POLY_ALT : 16'h0000);
      end
      default: begin
        // Reserved code falls back to the first 16-bit form
        crc_next = {crc_cur[14:0], 1'b0} ^ (fb16 ? `SPCD_POLY_CCITT : 16'h0000);
      end
    endcase
  end

endmodule // spcd_crc
`default_nettype wire

// ---- verilog/spcd_fifo.sv ----
`timescale 1ns/10ps
`default_nettype none

module spcd_fifo #(
  parameter int DW = 8,
  parameter int DEPTH = 8,
  parameter int AW = 3
) (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Fill side
  input wire logic push,
  input wire logic [DW-1:0] push_data,
  // Drain side
  input wire logic pop,
  output logic [DW-1:0] head_q,
  // Fill level
  output logic full,
  output logic empty
);

  // ----------------------------------------------------------------
  // Storage and pointers
  // ----------------------------------------------------------------
  logic [DW-1:0] mem_q [DEPTH]; // Byte store
  logic [AW-1:0] wr_ptr_q; // Next write slot
  logic [AW-1:0] rd_ptr_q; // Oldest slot
  logic [AW:0] count_q; // Bytes held
  logic do_push; // Accepted push
  logic do_pop; // Accepted pop

  assign full = (count_q == (AW+1)'(DEPTH));
  assign empty = (count_q == '0);
  assign do_push = push & ~full;
  assign do_pop = pop & ~empty;

  // Write port
  always_ff @(posedge clk) begin
    if (do_push) begin
      mem_q[wr_ptr_q] <= push_data;
    end
  end

  // Pointers and level
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q <= '0;
    end else begin
      if (do_push) begin
        wr_ptr_q <= wr_ptr_q + AW'(1);
      end
      if (do_pop) begin
        rd_ptr_q <= rd_ptr_q + AW'(1);
      end
      count_q <= count_q + (AW+1)'(do_push) - (AW+1)'(do_pop);
    end
  end

  // Registered head of queue
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      head_q <= '0;
    end else begin
      head_q <= mem_q[rd_ptr_q];
    end
  end

endmodule // spcd_fifo
`default_nettype wire

// ---- sim/spcd_top_assertions.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "spcd_defines.svh"
// ----------------------------------------
// Register bus and block flag checker
// ----------------------------------------
module spcd_top_assertions (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Bus request
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [17:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  // Bus answer and flag
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic block_irq
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  // Request first seen, its index and kind
  wire req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  wire [15:0] idx = wb_adr_i[17:2];
  wire rd = req && !wb_we_i;
  wire clr = req && wb_we_i && idx == `SPCD_IDX_IRQ_CLR && wb_sel_i[0]
    && wb_dat_i[0];
  a_ack_after_req: assert property (req |=> wb_ack_o)
    else $error("no ack after request");
  a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_irq_clear_drops: assert property (clr |=> !block_irq)
    else $error("block flag not cleared");
  a_irq_holds: assert property (block_irq && !clr |=> block_irq)
    else $error("block flag dropped alone");
  a_clear_reads_zero: assert property (
    rd && idx == `SPCD_IDX_CRC_CTRL |=> !wb_dat_o[12])
    else $error("crc clear bit reads one");
  a_crc_flags_valid: assert property (
    rd && idx == `SPCD_IDX_CRC_CTRL |=> wb_dat_o[10] | wb_dat_o[9])
    else $error("crc flags both zero");
  a_tx_len_width: assert property (
    rd && idx == `SPCD_IDX_TX_LEN |=> wb_dat_o[15:11] == 5'h0)
    else $error("tx count upper bits set");
  a_rx_len_width: assert property (
    rd && idx == `SPCD_IDX_RX_LEN |=> wb_dat_o[15:11] == 5'h0)
    else $error("rx count upper bits set");
  a_data_byte_only: assert property (
    rd && idx == `SPCD_IDX_DATA |=> wb_dat_o[15:8] == 8'h0)
    else $error("data upper bits set");
endmodule // spcd_top_assertions
bind spcd_top spcd_top_assertions i_spcd_top_assertions (.clk(clk),
  .sys_rst(sys_rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
  .wb_sel_i(wb_sel_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .block_irq(block_irq));
`default_nettype wire

// ---- sim/spcd_link_model.sv ----
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------
// Far-side serial master
// ----------------------------------------
module spcd_link_model (
  // Link pins
  output logic spi_sclk,
  output logic spi_sel_n,
  output logic spi_rx,
  input wire logic spi_tx
);
  // Idle: clock still, device deselected
  initial begin
    spi_sclk = 1'b0;
    spi_sel_n = 1'b1;
    spi_rx = 1'b0;
  end
  // One byte frame, 800 ns clock, MSB first
  task automatic frame(input logic [7:0] d, output logic [7:0] q);
    // Step off the sampling clock edge before touching any pin
    #20;
    spi_sel_n = 1'b0;
    #400;
    for (int i = 7; i >= 0; i--) begin
      spi_rx = d[i];
      #400 spi_sclk = 1'b1;
      #200 q[i] = spi_tx;
      #200 spi_sclk = 1'b0;
    end
    // Released line shows the inverse of its last bit
    spi_rx = ~spi_rx;
    #800 spi_sel_n = 1'b1;
    #800;
  endtask
endmodule // spcd_link_model
`default_nettype wire

// ---- sim/spi_crc_dma_data_regs_test.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "spcd_defines.svh"
module spi_crc_dma_data_regs_test;
  logic clk, sys_rst, cyc, stb, we, ack, sclk, sel_n, rxd, txd, irq;
  logic [17:0] adr;
  logic [31:0] wdat, rdat;
  logic [3:0] sel;
  logic [15:0] r, m, dra, dwa;
  logic [7:0] cap, d, dwd;
  int err_total, check_count, n;
  logic [15:0] ri [4] = '{`SPCD_IDX_TX_BASE, `SPCD_IDX_TX_LEN,
    `SPCD_IDX_RX_BASE, `SPCD_IDX_RX_LEN};
  logic [15:0] rv [4] = '{16'ha5c3, 16'h07ff, 16'h3c5a, 16'h0555};
  spcd_top i_spcd_top (.clk(clk), .sys_rst(sys_rst), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(wdat),
    .wb_sel_i(sel), .wb_dat_o(rdat), .wb_ack_o(ack), .spi_sclk(sclk),
    .spi_sel_n(sel_n), .spi_rx(rxd), .spi_tx(txd), .spi_tx_oe(),
    .dma_rd_addr(dra), .dma_rd_data(8'hc3), .dma_wr_valid(),
    .dma_wr_addr(dwa), .dma_wr_data(dwd), .block_irq(irq));
  spcd_link_model i_spcd_link_model (.spi_sclk(sclk), .spi_sel_n(sel_n),
    .spi_rx(rxd), .spi_tx(txd));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // Compare and count
  task automatic chk(input string s, input logic [15:0] e, g);
    check_count++;
    if (g !== e) begin
      err_total++;
      $display("ERROR %s exp %h got %h", s, e, g);
    end
  endtask
  // Classic single bus cycle, read data left in r
  task automatic wb(input logic w, input logic [15:0] i, d);
    @(posedge clk);
    {cyc, stb, we} <= {2'b11, w};
    adr <= {i, 2'b00};
    wdat <= {16'h0, d};
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    r = rdat[15:0];
    chk("ack", 16'h1, {15'h0, ack});
    {cyc, stb} <= 2'b00;
  endtask
  task automatic rdc(input logic [15:0] i, e, input string s);
    wb(1'b0, i, 16'h0);
    chk(s, e, r);
  endtask
  // Expected accumulator after byte b from all ones, MSB first
  function automatic logic [15:0] crc_of(input logic [1:0] p,
                                         input logic [7:0] b);
    logic [15:0] c;
    logic f;
    c = 16'hffff;
    for (int i = 7; i >= 0; i--) begin
      f = b[i] ^ ((p == 2'h1) ? c[6] : c[15]);
      if (p == 2'h1) c[6:0] = {c[5:0], 1'b0} ^ (f ? 7'h09 : 7'h00);
      else c = {c[14:0], 1'b0} ^ (f ? ((p == 2'h2) ? 16'h8005 : 16'h1021)
        : 16'h0000);
    end
    return c;
  endfunction
  task automatic print_verdict;
    $display("checks %0d errors %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial begin
    #500000;
    err_total++;
    print_verdict;
  end
  initial begin
    {cyc, stb, we, adr, wdat, sel, sys_rst} = {3'b000, 50'h0, 4'h3, 1'b1};
    {err_total, check_count} = 0;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    rdc(`SPCD_IDX_CRC_VAL, 16'hffff, "crc_val");
    rdc(`SPCD_IDX_CRC_CTRL, 16'h0400, "crc_ctrl");
    rdc(16'hc0e0, 16'h0, "unmapped");
    wb(1'b1, `SPCD_IDX_MODE, 16'h0005);
    n = 0;
    while (irq !== 1'b1 && n < 20) begin
      @(posedge clk);
      n++;
    end
    wb(1'b1, `SPCD_IDX_IRQ_CLR, 16'h0);
    chk("irq_kept", 16'h1, {15'h0, irq});
    wb(1'b1, `SPCD_IDX_IRQ_CLR, 16'h1);
    chk("irq_clr", 16'h0, {15'h0, irq});
    wb(1'b1, `SPCD_IDX_MODE, 16'h0);
    for (int k = 0; k < 4; k++) begin
      wb(1'b1, ri[k], rv[k]);
      rdc(ri[k], rv[k], "dma_reg");
    end
    wb(1'b1, `SPCD_IDX_CRC_VAL, 16'h0);
    rdc(`SPCD_IDX_CRC_CTRL, 16'h0200, "crc_ctrl");
    wb(1'b1, `SPCD_IDX_CRC_CTRL, 16'h1000);
    rdc(`SPCD_IDX_CRC_CTRL, 16'h0400, "crc_ctrl");
    for (int p = 0; p < 5; p++) begin
      if (p == 4) wb(1'b1, `SPCD_IDX_MODE, 16'h0002);
      m = (p == 4) ? 16'h3800 : {p[1:0], 14'h3000};
      wb(1'b1, `SPCD_IDX_CRC_CTRL, m);
      wb(1'b1, `SPCD_IDX_DATA, 16'h00a5);
      i_spcd_link_model.frame(8'h3c, cap);
      chk("tx_byte", 16'h00a5, {8'h0, cap});
      wb(1'b0, `SPCD_IDX_STAT, 16'h0);
      chk("rx_ready", 16'h1, {15'h0, r[1]});
      rdc(`SPCD_IDX_DATA, 16'h003c, "rx_byte");
      wb(1'b0, `SPCD_IDX_STAT, 16'h0);
      chk("rx_empty", 16'h0, {15'h0, r[1]});
      m = (p == 1) ? 16'h007f : 16'hffff;
      wb(1'b0, `SPCD_IDX_CRC_VAL, 16'h0);
      d = (p == 4) ? 8'h3c : 8'ha5;
      chk("crc", crc_of(p[1:0], d) & m, r & m);
    end
    // One-byte block: fetch from tx base, store at rx base
    wb(1'b1, `SPCD_IDX_TX_LEN, 16'h0001);
    wb(1'b1, `SPCD_IDX_RX_LEN, 16'h0001);
    wb(1'b1, `SPCD_IDX_MODE, 16'h0005);
    i_spcd_link_model.frame(8'h5a, cap);
    chk("dma_tx", 16'h00c3, {8'h0, cap});
    chk("dma_raddr", 16'ha5c3, dra);
    chk("dma_rx", 16'h005a, {8'h0, dwd});
    chk("dma_waddr", 16'h3c5a, dwa);
    chk("blk_irq", 16'h1, {15'h0, irq});
    print_verdict;
  end
endmodule // spi_crc_dma_data_regs_test
`default_nettype wire
